// ---- asb_bus_map.svh ----
/*
  Shared constants of the system-bus link: transaction-type codes, size codes,
  line length and burst page width.
  Assumes it is included by bare name from the package and both ends.
*/
`ifndef ASB_BUS_MAP_SVH
`define ASB_BUS_MAP_SVH

// ----------------------------------------
// transaction type, announces the next bus cycle
// ----------------------------------------
`define TRAN_ADDR 2'h0
`define TRAN_RSVD 2'h1
`define TRAN_NSEQ 2'h2
`define TRAN_SEQ 2'h3

// ----------------------------------------
// access size
// ----------------------------------------
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// ----------------------------------------
// bursts and lines
// ----------------------------------------
`define LINE_WORDS 4
// byte-address bits inside one 256-word page
`define PAGE_BITS 10

`endif

// ---- asb_pkg.sv ----
/*
  Types of the master end of the system-bus link, also used by the bench.
  Assumes asb_bus_map.svh is on the include path.
*/
`include "asb_bus_map.svh"

package asb_pkg;

  // core requests handed to the master end
  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE_BUF,
    OP_WRITE,
    OP_FILL,
    OP_SWAP
  } op_t;

  // which cycle the master has announced for the next bus cycle
  typedef enum logic [1:0] {
    MS_IDLE,
    MS_ADDR,
    MS_MEM,
    MS_FIN
  } mst_state_t;

endpackage

// ---- asb_link_if.sv ----
/*
  The system bus between the processor-side master and one slave.
  Assumes the bench drives bclk; the shared data bus is resolved here from the
  two drive enables, so neither end ever needs a floating level.
*/
`timescale 1ns/1ps

interface asb_link_if (
  input wire logic bclk
);
  logic [31:0] baddr;
  logic bwrite;
  logic [1:0] bsize;
  logic blok;
  logic [1:0] btran;
  logic [31:0] bd_m;
  logic bd_m_oe;
  logic [31:0] bd_s;
  logic bd_s_oe;
  logic [31:0] bd;
  logic berror;
  logic bwait;

  // master wins while writing; zero only if nobody drives
  assign bd = bd_m_oe ? bd_m : (bd_s_oe ? bd_s : 32'h0000_0000);

  modport master (
    input bclk, bd, berror, bwait,
    output baddr, bwrite, bsize, blok, btran, bd_m, bd_m_oe
  );
  modport slave (
    input bclk, baddr, bwrite, bsize, blok, btran, bd,
    output bd_s, bd_s_oe, berror, bwait
  );
endinterface

// ---- bus_slave_end.sv ----
/*
  Memory-controller end of the system bus: a small flop memory that answers
  every memory cycle, with programmable wait and error injection.
  Assumes a single master on the bus; config inputs are quasi-static levels.
*/
`timescale 1ns/1ps
`include "asb_bus_map.svh"

module bus_slave_end #(
  parameter int DEPTH = 16,
  parameter int WAIT_W = 2
) (
  // user side, mclk domain
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [WAIT_W-1:0] cfg_wait,
  input wire logic cfg_err_en,
  input wire logic [$clog2(DEPTH)-1:0] cfg_err_word,
  output logic [15:0] beat_count,
  output logic locked,
  // link
  asb_link_if.slave bus
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = WAIT_W + 1 + AW;

  logic [1:0] rst_s_q;
  logic [CW-1:0] cfg1_q;
  logic [CW-1:0] cfg2_q;
  logic [WAIT_W-1:0] c_wait;
  logic c_err_en;
  logic [AW-1:0] c_err_word;
  logic mem_cyc_q;
  logic wr_q;
  logic [AW-1:0] idx_q;
  logic [WAIT_W-1:0] wcnt_q;
  logic bwait_q;
  logic berror_q;
  logic oe_q;
  logic [31:0] bd_q;
  logic [31:0] mem_q [DEPTH];
  logic ev_tgl_q;
  logic [2:0] ev_s_q;
  logic [1:0] lok_s_q;
  logic link_rst;
  logic [AW-1:0] word;
  logic seq_next;

  assign link_rst = rst_s_q[1];
  assign {c_wait, c_err_en, c_err_word} = cfg2_q;
  assign word = bus.baddr[AW+1:2];
  assign seq_next = bus.btran == `TRAN_SEQ || bus.btran == `TRAN_NSEQ;

  assign bus.bwait = bwait_q;
  assign bus.berror = berror_q;
  assign bus.bd_s_oe = oe_q;
  assign bus.bd_s = bd_q;

  // ----------------------------------------
  // crossings into the link domain
  // ----------------------------------------
  always_ff @(negedge bus.bclk) begin
    rst_s_q <= {rst_s_q[0], sys_rst};
    cfg1_q <= {cfg_wait, cfg_err_en, cfg_err_word};
    cfg2_q <= cfg1_q;
  end

  // ----------------------------------------
  // bus cycle tracking, wait and error
  // ----------------------------------------
  // all slave link outputs change at the falling edge, i.e. in the low phase
  always_ff @(negedge bus.bclk) begin
    if (link_rst) begin
      mem_cyc_q <= 1'b0;
      wr_q <= 1'b0;
      idx_q <= '0;
      wcnt_q <= '0;
      bwait_q <= 1'b0;
      berror_q <= 1'b0;
      oe_q <= 1'b1;
      bd_q <= 32'h0000_0000;
    end else if (!bwait_q) begin
      // type is taken only at a real boundary, so a stretched cycle is never seen as address
      mem_cyc_q <= seq_next;
      if (seq_next) begin
        idx_q <= word;
        wr_q <= bus.bwrite;
        wcnt_q <= c_wait;
        bwait_q <= c_wait != '0;
        berror_q <= c_err_en && word == c_err_word;
        oe_q <= !bus.bwrite;
        bd_q <= mem_q[word];
      end else begin
        berror_q <= 1'b0;
        oe_q <= 1'b1;
      end
    end else begin
      wcnt_q <= wcnt_q - 1'b1;
      bwait_q <= wcnt_q > 1;
    end
  end

  // ----------------------------------------
  // storage and beat events
  // ----------------------------------------
  always_ff @(negedge bus.bclk) begin
    if (link_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= 32'h0000_0000;
      end
      ev_tgl_q <= 1'b0;
    end else if (!bwait_q && mem_cyc_q) begin
      if (wr_q) begin
        mem_q[idx_q] <= bus.bd;
      end
      ev_tgl_q <= ~ev_tgl_q;
    end
  end

  // ----------------------------------------
  // user side
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    ev_s_q <= {ev_s_q[1:0], ev_tgl_q};
    lok_s_q <= {lok_s_q[0], bus.blok};
    if (sys_rst) begin
      beat_count <= 16'h0000;
      locked <= 1'b0;
    end else begin
      if (ev_s_q[2] != ev_s_q[1]) begin
        beat_count <= beat_count + 16'h0001;
      end
      // sole master here, so a lock needs no arbitration hold-off
      locked <= lok_s_q[1];
    end
  end
endmodule

// ---- bus_master_end.sv ----
/*
  Processor-side master of the system bus: takes one core request at a time
  from the mclk domain and runs it on the bus in the bclk domain.
  Assumes the bench runs bclk whenever sys_rst is applied and a slave answers.
*/
// What this block does
// - type codes: 00 address/idle, 10 non-sequential
// - code 11 announces sequential next cycle
// - master itself never drives non-sequential code
// - read data captured at memory-cycle end
// - write data launched at memory-cycle start
// - stretched write keeps data valid throughout
// - system keeps some data driver enabled
// - error sampled rising edge every memory cycle
// - errors on buffered writes are ignored
// - line fill always fetches four words
// - fill aborts only on requested word errors
// - any fill error keeps line uncached
// - slave raises wait in low phase
// - type and write data held during wait
// - address, direction, size, lock frozen during wait
// - slave samples type only after unwaited edge
// - stretched single cycle is not address cycle
// - burst continues only same direction, consecutive
// - 256-word boundary restarts with address cycle
// - swap: locked read then write, same address
// - slave allows nothing between locked accesses
// - swap read is single external read
// - swap write unbuffered, updates cache unless it errors
`timescale 1ns/1ps
`include "asb_bus_map.svh"

module bus_master_end #(
  parameter int BEATS = `LINE_WORDS
) (
  // core side, mclk domain
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire asb_pkg::op_t cmd_op,
  input wire logic [31:0] cmd_addr,
  input wire logic [1:0] cmd_size,
  input wire logic [$clog2(BEATS)-1:0] cmd_len,
  input wire logic [BEATS-1:0] cmd_need,
  input wire logic [31:0] cmd_wdata [BEATS],
  // result
  output logic rsp_valid,
  output logic [31:0] rsp_rdata [BEATS],
  output logic rsp_abort,
  output logic rsp_fill_ok,
  output logic rsp_cache_upd,
  output logic [BEATS-1:0] rsp_err,
  // link
  asb_link_if.master bus
);
  localparam int LW = $clog2(BEATS);

  // mclk side
  logic req_tgl_q;
  logic [2:0] ack_s_q;
  asb_pkg::op_t h_op_q;
  logic [31:0] h_addr_q;
  logic [1:0] h_size_q;
  logic [LW-1:0] h_len_q;
  logic [BEATS-1:0] h_need_q;
  logic [31:0] h_wdata_q [BEATS];
  // bclk side
  logic [1:0] rst_s_q;
  logic [2:0] req_s_q;
  asb_pkg::mst_state_t st_q;
  asb_pkg::op_t op_q;
  logic [31:0] addr_q;
  logic write_q;
  logic [1:0] size_q;
  logic lock_q;
  logic [1:0] btran_q;
  logic [LW-1:0] idx_q;
  logic [LW-1:0] left_q;
  logic ack_tgl_q;
  logic abort_q;
  logic cache_upd_q;
  logic [BEATS-1:0] err_q;
  logic wait_s_q;
  logic cyc_mem_q;
  logic cyc_wr_q;
  logic [LW-1:0] cyc_idx_q;
  logic bd_oe_q;
  logic [31:0] bd_q;
  logic [31:0] rdata_q [BEATS];
  logic link_rst;
  logic start;
  logic beat_done;
  logic abort_now;
  logic swap_rd;
  logic [31:0] nxt_addr;

  assign link_rst = rst_s_q[1];
  assign start = st_q == asb_pkg::MS_IDLE && req_s_q[2] != req_s_q[1];
  assign beat_done = st_q == asb_pkg::MS_MEM && !bus.bwait;
  assign swap_rd = op_q == asb_pkg::OP_SWAP && !write_q;
  // a buffered write cannot be aborted; a fill aborts only for words the core wants
  assign abort_now = beat_done && bus.berror && op_q != asb_pkg::OP_WRITE_BUF
    && (op_q != asb_pkg::OP_FILL || h_need_q[idx_q]);
  assign nxt_addr = addr_q + (size_q == `SIZE_HALF ? 32'h0000_0002 : 32'h0000_0004);

  assign bus.baddr = addr_q;
  assign bus.bwrite = write_q;
  assign bus.bsize = size_q;
  assign bus.blok = lock_q;
  assign bus.btran = btran_q;
  assign bus.bd_m = bd_q;
  assign bus.bd_m_oe = bd_oe_q;

  // ----------------------------------------
  // core handshake, mclk domain
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    ack_s_q <= {ack_s_q[1:0], ack_tgl_q};
    if (sys_rst) begin
      cmd_ready <= 1'b0;
      req_tgl_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_abort <= 1'b0;
      rsp_fill_ok <= 1'b0;
      rsp_cache_upd <= 1'b0;
      rsp_err <= '0;
      for (int i = 0; i < BEATS; i++) begin
        rsp_rdata[i] <= 32'h0000_0000;
      end
    end else begin
      rsp_valid <= 1'b0;
      if (cmd_valid && cmd_ready) begin
        cmd_ready <= 1'b0;
        req_tgl_q <= ~req_tgl_q;
      end else if (ack_s_q[2] != ack_s_q[1]) begin
        // link results stand still until the next request, so they are safe to take here
        cmd_ready <= 1'b1;
        rsp_valid <= 1'b1;
        rsp_abort <= abort_q;
        rsp_fill_ok <= h_op_q == asb_pkg::OP_FILL && err_q == '0;
        rsp_cache_upd <= cache_upd_q;
        rsp_err <= err_q;
        rsp_rdata <= rdata_q;
      end else if (req_tgl_q == ack_s_q[1]) begin
        cmd_ready <= 1'b1;
      end
    end
  end

  // request is held stable while it is in flight on the link
  always_ff @(posedge mclk) begin
    if (cmd_valid && cmd_ready) begin
      h_op_q <= cmd_op;
      h_addr_q <= cmd_addr;
      h_size_q <= cmd_size;
      h_len_q <= cmd_len;
      h_need_q <= cmd_need;
      h_wdata_q <= cmd_wdata;
    end
  end

  // ----------------------------------------
  // bus sequencer, rising edge of bclk
  // ----------------------------------------
  always_ff @(posedge bus.bclk) begin
    rst_s_q <= {rst_s_q[0], sys_rst};
    req_s_q <= {req_s_q[1:0], req_tgl_q};
    wait_s_q <= bus.bwait;
  end

  always_ff @(posedge bus.bclk) begin
    if (link_rst) begin
      st_q <= asb_pkg::MS_IDLE;
      op_q <= asb_pkg::OP_READ;
      addr_q <= 32'h0000_0000;
      write_q <= 1'b0;
      size_q <= `SIZE_WORD;
      lock_q <= 1'b0;
      btran_q <= `TRAN_ADDR;
      idx_q <= '0;
      left_q <= '0;
      ack_tgl_q <= 1'b0;
    end else if (!bus.bwait) begin
      unique case (st_q)
        asb_pkg::MS_IDLE: begin
          if (start) begin
            op_q <= h_op_q;
            write_q <= h_op_q == asb_pkg::OP_WRITE_BUF || h_op_q == asb_pkg::OP_WRITE;
            idx_q <= '0;
            btran_q <= `TRAN_ADDR;
            st_q <= asb_pkg::MS_ADDR;
            // swap read always goes out, one word, with its own address cycle
            lock_q <= h_op_q == asb_pkg::OP_SWAP;
            if (h_op_q == asb_pkg::OP_FILL) begin
              addr_q <= h_addr_q & ~32'(BEATS * 4 - 1);
              size_q <= `SIZE_WORD;
              left_q <= LW'(BEATS - 1);
            end else begin
              addr_q <= h_addr_q;
              size_q <= h_op_q == asb_pkg::OP_SWAP ? `SIZE_WORD : h_size_q;
              // bytes cannot burst, swaps are single
              left_q <= (h_op_q == asb_pkg::OP_SWAP || h_size_q == `SIZE_BYTE) ? '0 : h_len_q;
            end
          end
        end
        asb_pkg::MS_ADDR: begin
          btran_q <= `TRAN_SEQ;
          st_q <= asb_pkg::MS_MEM;
        end
        asb_pkg::MS_MEM: begin
          // locked pair is never split: an aborted swap read still runs its write, so lock ends there
          if ((abort_now && op_q != asb_pkg::OP_FILL && !swap_rd) || (left_q == '0 && !swap_rd)) begin
            btran_q <= `TRAN_ADDR;
            lock_q <= 1'b0;
            st_q <= asb_pkg::MS_FIN;
          end else if (swap_rd) begin
            // direction change forces a fresh address cycle, same address
            write_q <= 1'b1;
            btran_q <= `TRAN_ADDR;
            st_q <= asb_pkg::MS_ADDR;
          end else begin
            addr_q <= nxt_addr;
            idx_q <= idx_q + 1'b1;
            left_q <= left_q - 1'b1;
            // crossing a page restarts via an address cycle, never the reserved or 10 code
            if (nxt_addr[`PAGE_BITS-1:0] == '0) begin
              btran_q <= `TRAN_ADDR;
              st_q <= asb_pkg::MS_ADDR;
            end else begin
              btran_q <= `TRAN_SEQ;
            end
          end
        end
        asb_pkg::MS_FIN: begin
          ack_tgl_q <= ~ack_tgl_q;
          st_q <= asb_pkg::MS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // slave responses, rising edge of bclk
  // ----------------------------------------
  always_ff @(posedge bus.bclk) begin
    if (link_rst || start) begin
      abort_q <= 1'b0;
      cache_upd_q <= 1'b0;
      err_q <= '0;
    end else if (beat_done) begin
      if (bus.berror && op_q != asb_pkg::OP_WRITE_BUF) begin
        err_q[idx_q] <= 1'b1;
      end
      if (abort_now) begin
        abort_q <= 1'b1;
      end
      if (op_q == asb_pkg::OP_SWAP && write_q && !bus.berror) begin
        cache_upd_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // data bus, falling edge of bclk
  // ----------------------------------------
  // a bus cycle ends only at a falling edge whose preceding rising edge saw no wait
  always_ff @(negedge bus.bclk) begin
    if (link_rst) begin
      cyc_mem_q <= 1'b0;
      cyc_wr_q <= 1'b0;
      cyc_idx_q <= '0;
      bd_oe_q <= 1'b0;
      bd_q <= 32'h0000_0000;
    end else if (!wait_s_q) begin
      cyc_mem_q <= btran_q == `TRAN_SEQ;
      cyc_wr_q <= write_q;
      cyc_idx_q <= idx_q;
      bd_oe_q <= btran_q == `TRAN_SEQ && write_q;
      if (btran_q == `TRAN_SEQ && write_q) begin
        bd_q <= h_wdata_q[idx_q];
      end
    end
  end

  always_ff @(negedge bus.bclk) begin
    if (!link_rst && !wait_s_q && cyc_mem_q && !cyc_wr_q) begin
      rdata_q[cyc_idx_q] <= bus.bd;
    end
  end
endmodule

// ---- asb_link_assertions.sv ----
/*
  Concurrent checks on the system-bus link between master and slave ends.
  Assumes it is instantiated in the bench top beside the link interface.
*/
`timescale 1ns/1ps
`include "asb_bus_map.svh"

module asb_link_assertions (
  // link
  input wire logic bclk,
  input wire logic sys_rst,
  input wire logic [31:0] baddr,
  input wire logic bwrite,
  input wire logic [1:0] bsize,
  input wire logic blok,
  input wire logic [1:0] btran,
  input wire logic [31:0] bd_m,
  input wire logic bd_m_oe,
  input wire logic bd_s_oe,
  input wire logic berror,
  input wire logic bwait
);
  default clocking cb @(posedge bclk);
  endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // transaction type
  // ----------------------------------------
  AST_NO_RSVD: assert property (btran != `TRAN_RSVD)
    else $error("reserved transaction type driven");
  AST_NO_NSEQ: assert property (btran != `TRAN_NSEQ)
    else $error("master drove non-sequential type");
  AST_TRAN_HOLD: assert property (bwait |=> $stable(btran))
    else $error("transaction type moved during wait");
  AST_DIR_CHANGE: assert property ($changed(bwrite) |-> btran == `TRAN_ADDR)
    else $error("direction changed inside a burst");
  AST_PAGE_CROSS: assert property ($changed(baddr) && baddr[9:0] == 10'h000 |-> btran == `TRAN_ADDR)
    else $error("page boundary word not started with address cycle");

  // ----------------------------------------
  // addressing and write data
  // ----------------------------------------
  AST_ADDR_HOLD: assert property (bwait |=> $stable({baddr, bwrite, bsize, blok}))
    else $error("addressing moved during wait");
  // a memory cycle runs when the announce was seen at an unwaited edge
  AST_WDATA_LAUNCH: assert property (bwrite && btran == `TRAN_SEQ && !$past(bwait) |-> bd_m_oe)
    else $error("write data not driven in memory cycle");
  AST_WDATA_HOLD: assert property (bd_m_oe && bwait |=> bd_m_oe && $stable(bd_m))
    else $error("write data lost during wait");
  // a floating data bus burns power in every receiver
  AST_BUS_DRIVEN: assert property (bd_m_oe || bd_s_oe)
    else $error("data bus left undriven");

  // ----------------------------------------
  // locked swap
  // ----------------------------------------
  AST_LOCK_START: assert property ($rose(blok) |-> !bwrite && btran == `TRAN_ADDR)
    else $error("lock raised outside a read address cycle");
  AST_LOCK_END: assert property ($fell(blok) |-> bwrite)
    else $error("lock dropped outside the write");

  cover property (bwait && bd_m_oe);
  cover property ($rose(blok));
  cover property (berror && btran == `TRAN_SEQ);
endmodule

// ---- asb_master_data_response_lock_tb_top.sv ----
/*
  Self-checking bench joining master and slave ends over the link.
  Assumes the link carries bclk from this bench, unrelated to mclk.
*/
`timescale 1ns/1ps
`include "asb_bus_map.svh"

`define CHK(nm, exp, got) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    $display("unexpected %s: exp %h got %h", nm, exp, got); \
    n_mismatch++; \
  end \
end

module asb_master_data_response_lock_tb_top;
  typedef struct packed {
    asb_pkg::op_t op;
    logic [31:0] a;
    logic [1:0] len;
    logic [1:0] wt;
    logic err;
    logic abort;
  } row_t;

  logic mclk = 1'b0;
  logic bclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  asb_pkg::op_t cmd_op = asb_pkg::OP_READ;
  logic [31:0] cmd_addr = 32'h0000_0000;
  logic [1:0] cmd_size = `SIZE_WORD;
  logic [1:0] cmd_len = 2'h0;
  logic [3:0] cmd_need = 4'h0;
  logic [31:0] cmd_wdata [4];
  logic cmd_ready, rsp_valid, rsp_abort, rsp_fill_ok, rsp_cache_upd, locked;
  logic [31:0] rsp_rdata [4];
  logic [3:0] rsp_err;
  logic [1:0] cfg_wait = 2'h0;
  logic cfg_err_en = 1'b0;
  logic [3:0] cfg_err_word = 4'h5;
  logic [15:0] beat_count;
  logic [31:0] mem [16];
  logic [15:0] salt = 16'h1111;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic lock_seen = 1'b0;
  // index 5 is the error word; rows 7 and 8 run across 0x400
  row_t rows [9] = '{
    '{asb_pkg::OP_WRITE, 32'h0000_0000, 2'h3, 2'h0, 1'b0, 1'b0},
    '{asb_pkg::OP_READ, 32'h0000_0000, 2'h3, 2'h1, 1'b0, 1'b0},
    '{asb_pkg::OP_WRITE, 32'h0000_0020, 2'h1, 2'h2, 1'b0, 1'b0},
    '{asb_pkg::OP_READ, 32'h0000_0020, 2'h1, 2'h3, 1'b0, 1'b0},
    '{asb_pkg::OP_WRITE_BUF, 32'h0000_0014, 2'h0, 2'h0, 1'b1, 1'b0},
    '{asb_pkg::OP_READ, 32'h0000_0014, 2'h0, 2'h0, 1'b1, 1'b1},
    '{asb_pkg::OP_WRITE, 32'h0000_0014, 2'h0, 2'h1, 1'b1, 1'b1},
    '{asb_pkg::OP_WRITE, 32'h0000_03F8, 2'h3, 2'h1, 1'b0, 1'b0},
    '{asb_pkg::OP_READ, 32'h0000_03F8, 2'h3, 2'h0, 1'b0, 1'b0}
  };

  always #5 mclk = ~mclk;
  always #6 bclk = ~bclk;

  // sticky, since the synced lock is too short to poll from a blocking task
  always @(posedge mclk) lock_seen <= lock_seen | (locked === 1'b1);

  // ----------------------------------------
  // link, ends and checker
  // ----------------------------------------
  asb_link_if i_asb_link_if (.bclk(bclk));

  bus_master_end i_bus_master_end (
    .mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_size(cmd_size), .cmd_len(cmd_len), .cmd_need(cmd_need),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_abort(rsp_abort),
    .rsp_fill_ok(rsp_fill_ok), .rsp_cache_upd(rsp_cache_upd), .rsp_err(rsp_err), .bus(i_asb_link_if)
  );

  bus_slave_end i_bus_slave_end (
    .mclk(mclk), .sys_rst(sys_rst), .cfg_wait(cfg_wait), .cfg_err_en(cfg_err_en),
    .cfg_err_word(cfg_err_word), .beat_count(beat_count), .locked(locked), .bus(i_asb_link_if)
  );

  asb_link_assertions i_asb_link_assertions (
    .bclk(bclk), .sys_rst(sys_rst), .baddr(i_asb_link_if.baddr), .bwrite(i_asb_link_if.bwrite),
    .bsize(i_asb_link_if.bsize), .blok(i_asb_link_if.blok), .btran(i_asb_link_if.btran),
    .bd_m(i_asb_link_if.bd_m), .bd_m_oe(i_asb_link_if.bd_m_oe), .bd_s_oe(i_asb_link_if.bd_s_oe),
    .berror(i_asb_link_if.berror), .bwait(i_asb_link_if.bwait)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {salt, a[15:0]};
  endfunction

  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // config crosses with two flops only, so let it settle first
  task automatic set_cfg(input logic [1:0] wt, input logic en, input logic [3:0] wd);
    @(posedge mclk);
    cfg_wait <= wt;
    cfg_err_en <= en;
    cfg_err_word <= wd;
    repeat (8) @(posedge mclk);
  endtask

  task automatic do_op(input asb_pkg::op_t op, input logic [31:0] a, input logic [1:0] len,
                       input logic [3:0] need);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 500) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 500) begin
      n_mismatch++;
      wrap_up();
    end
    @(posedge mclk);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_len <= len;
    cmd_need <= need;
    for (int i = 0; i < 4; i++) cmd_wdata[i] <= pat(a + 32'(4 * i));
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 3000) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    logic [3:0] w;
    logic [15:0] bc;
    logic [31:0] old;
    foreach (cmd_wdata[i]) cmd_wdata[i] = 32'h0000_0000;
    foreach (mem[i]) mem[i] = 32'h0000_0000;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge mclk);
    foreach (rows[k]) begin
      salt = salt + 16'h0101;
      set_cfg(rows[k].wt, rows[k].err, 4'h5);
      do_op(rows[k].op, rows[k].a, rows[k].len, 4'h0);
      `CHK("abort", rows[k].abort, rsp_abort)
      for (int i = 0; i <= int'(rows[k].len); i++) begin
        w = rows[k].a[5:2] + 4'(i);
        if (rows[k].op == asb_pkg::OP_READ && !rows[k].err) `CHK("rdata", mem[w], rsp_rdata[i])
        if (rows[k].op == asb_pkg::OP_WRITE && !rows[k].err) mem[w] = pat(rows[k].a + 32'(4 * i));
      end
      $display("row %0d done", k);
    end
    // half-word burst steps by two, so both beats hit word 0
    @(posedge mclk);
    cmd_size <= `SIZE_HALF;
    bc = beat_count;
    do_op(asb_pkg::OP_READ, 32'h0000_0000, 2'h1, 4'h0);
    `CHK("half beats", bc + 16'h0002, beat_count)
    `CHK("half data", mem[0], rsp_rdata[1])
    @(posedge mclk);
    cmd_size <= `SIZE_BYTE;
    bc = beat_count;
    do_op(asb_pkg::OP_READ, 32'h0000_0004, 2'h3, 4'h0);
    `CHK("byte beats", bc + 16'h0001, beat_count)
    `CHK("byte data", mem[1], rsp_rdata[0])
    @(posedge mclk);
    cmd_size <= `SIZE_WORD;
    $display("size test done");
    // second reset in mid-run clears the slave memory too
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge mclk);
    `CHK("lock in reset", 1'b0, i_asb_link_if.blok)
    `CHK("type in reset", `TRAN_ADDR, i_asb_link_if.btran)
    sys_rst <= 1'b0;
    foreach (mem[i]) mem[i] = 32'h0000_0000;
    repeat (8) @(posedge mclk);
    $display("reset test done");
    for (int c = 0; c < 3; c++) begin
      set_cfg(2'h1, c != 0, 4'hA);
      bc = beat_count;
      do_op(asb_pkg::OP_FILL, 32'h0000_0024, 2'h0, (c == 2) ? 4'h4 : 4'h1);
      `CHK("fill beats", bc + 16'h0004, beat_count)
      `CHK("fill abort", c == 2, rsp_abort)
      `CHK("fill ok", c == 0, rsp_fill_ok)
      `CHK("fill err", (c == 0) ? 4'h0 : 4'h4, rsp_err)
      if (c == 0) for (int i = 0; i < 4; i++) `CHK("fill data", mem[8 + i], rsp_rdata[i])
      $display("fill %0d done", c);
    end
    set_cfg(2'h2, 1'b0, 4'h8);
    do_op(asb_pkg::OP_WRITE, 32'h0000_0020, 2'h0, 4'h0);
    old = pat(32'h0000_0020);
    `CHK("lock seen before swap", 1'b0, lock_seen)
    salt = salt + 16'h0101;
    bc = beat_count;
    do_op(asb_pkg::OP_SWAP, 32'h0000_0020, 2'h0, 4'h0);
    `CHK("swap old", old, rsp_rdata[0])
    `CHK("swap beats", bc + 16'h0002, beat_count)
    `CHK("swap upd", 1'b1, rsp_cache_upd)
    `CHK("lock seen", 1'b1, lock_seen)
    `CHK("locked after swap", 1'b0, locked)
    do_op(asb_pkg::OP_READ, 32'h0000_0020, 2'h0, 4'h0);
    `CHK("swap new", pat(32'h0000_0020), rsp_rdata[0])
    set_cfg(2'h0, 1'b1, 4'h8);
    do_op(asb_pkg::OP_SWAP, 32'h0000_0020, 2'h0, 4'h0);
    `CHK("swap err abort", 1'b1, rsp_abort)
    `CHK("swap err upd", 1'b0, rsp_cache_upd)
    $display("swap test done");
    wrap_up();
  end
endmodule
